// ### bench/testbench.sv
// self-checking bench for the touch rc-oscillator counter
module testbench
   import trcoc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk_sys, rst, en, ovsel, div4, run_set, run_clear, fclr, wr, rd, osc;
   logic       run, flag, req, rd_d = 1'b0;
   logic [7:0] wdata, rdata, osc_half = 8'h25;
   logic [7:0] exp_q[$];
   logic [1:0] b;
   logic [31:0] lf = 32'h9822;
   trcoc_sel_t sel;
   int         num_errors = 0, comparisons = 0, n;
   trcoc_top u_trcoc_top (.clk_sys(clk_sys), .rst(rst), .conv_enable_bit(en),
      .overflow_source_select(ovsel), .ref_clock_select_bit0(div4),
      .ref_clock_select_bit1(1'b0), .ref_clock_select_bit2(1'b0), .run_set(run_set),
      .run_clear(run_clear), .irq_flag_clear(fclr), .rc_osc_in(osc), .acc_wr(wr),
      .acc_rd(rd), .acc_sel(sel), .acc_wdata(wdata), .acc_rdata(rdata),
      .count_run_bit(run), .conv_irq_flag(flag), .conv_irq_req(req));
   trcoc_rc_osc_model u_trcoc_rc_osc_model (.run(en), .half_ns(osc_half), .osc(osc));
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic cyc();
      @(posedge clk_sys) #1;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rng(input int lo, input int hi);
      check(16'(n >= lo && n <= hi), 16'h0001);
   endtask
   // strobe held one cycle, then one idle cycle so it is never re-driven in one step
   task automatic acc(input logic w, input logic [1:0] s, input logic [7:0] d);
      wr = w;
      rd = ~w;
      sel = trcoc_sel_t'(s);
      wdata = d;
      cyc();
      wr = 1'b0;
      rd = 1'b0;
      cyc();
   endtask
   task automatic wr16(input logic [1:0] s, input logic [15:0] v);
      acc(1'b1, s, v[7:0]);
      acc(1'b1, s | 2'h1, v[15:8]);
   endtask
   task automatic rd16(input logic [1:0] s, input logic [15:0] v);
      exp_q.push_back(v[15:8]);
      acc(1'b0, s | 2'h1, 8'h00);
      exp_q.push_back(v[7:0]);
      acc(1'b0, s, 8'h00);
   endtask
   // clear the flag, start a run and count cycles up to the overflow pulse
   task automatic go();
      fclr = 1'b1;
      cyc();
      fclr = 1'b0;
      run_set = 1'b1;
      cyc();
      run_set = 1'b0;
      // byte accesses while counting must change nothing
      acc(1'b1, 2'h1, 8'h55);
      acc(1'b0, 2'h3, 8'h00);
      n = 4;
      while (req !== 1'b1 && n < 2000)
      begin
         cyc();
         n++;
      end
   endtask
   task give_verdict();
      $display("errors=%0d comparisons=%0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // clock, watchdog and read-data watcher
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial
   begin
      #100us;
      num_errors++;
      give_verdict();
   end
   always @(posedge clk_sys)
   begin
      if (rd_d)
         check(rdata, exp_q.pop_front());
      rd_d <= rd && !run;
   end
   ////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      {ovsel, div4, run_set, run_clear, fclr, wr, rd, wdata} = '0;
      en = 1'b1;
      sel = TRCOC_SEL_REF_LOW;
      rst = 1'b1;
      repeat (16) cyc();
      rst = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         lf = lfsr(lf);
         b = i[0] ? 2'h2 : 2'h0;
         wr16(b, lf[15:0]);
         rd16(b, lf[15:0]);
         acc(1'b1, b, ~lf[7:0]);
         rd16(b, lf[15:0]);
      end
      en = 1'b0;
      run_set = 1'b1;
      cyc();
      run_set = 1'b0;
      cyc();
      check(run, 1'b0);
      en = 1'b1;
      for (int d = 0; d < 2; d++)
      begin
         div4 = d[0];
         wr16(2'h2, 16'h0000);
         wr16(2'h0, 16'hFFF0);
         go();
         if (d == 0) rng(15, 18);
         else rng(55, 70);
         check({flag, run}, 2'h2);
         rd16(2'h0, 16'h0000);
      end
      div4 = 1'b0;
      ovsel = 1'b1;
      for (int h = 37; h < 80; h += 37)
      begin
         osc_half = 8'(h);
         wr16(2'h0, 16'h0000);
         wr16(2'h2, 16'hFFF8);
         go();
         // oscillator phase is free: eight rises take seven to eight periods plus sync
         rng(h * 14 / 10 - 2, h * 16 / 10 + 5);
         rd16(2'h2, 16'h0000);
      end
      ovsel = 1'b0;
      wr16(2'h0, 16'h0000);
      fclr = 1'b1;
      run_set = 1'b1;
      cyc();
      {fclr, run_set, run_clear} = 3'h1;
      cyc();
      run_clear = 1'b0;
      cyc();
      check({flag, run, req}, 3'h0);
      give_verdict();
   end
endmodule

// ### bench/trcoc_properties.sv
// concurrent checks on the touch counter block ports
module trcoc_properties (
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       conv_enable_bit,
   input wire logic       run_set,
   input wire logic       run_clear,
   input wire logic       irq_flag_clear,
   input wire logic [7:0] acc_rdata,
   input wire logic       count_run_bit,
   input wire logic       conv_irq_flag,
   input wire logic       conv_irq_req
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////
   // overflow event, run bit and flag move together
   property p_req_stops; conv_irq_req |-> conv_irq_flag && !count_run_bit; endproperty
   property p_req_pulse; conv_irq_req |=> !conv_irq_req; endproperty
   property p_req_cause; conv_irq_req |-> $past(count_run_bit); endproperty
   property p_run_start; $rose(count_run_bit) |-> $past(run_set && conv_enable_bit); endproperty
   property p_run_end; $fell(count_run_bit) |-> conv_irq_req || $past(run_clear); endproperty
   property p_flag_hold; conv_irq_flag && !irq_flag_clear |=> conv_irq_flag; endproperty
   property p_flag_set; $rose(conv_irq_flag) |-> conv_irq_req; endproperty
   // a read taken while counting would move the read data
   property p_rdata_frozen; count_run_bit |=> $stable(acc_rdata); endproperty
   a_req_stops: assert property (p_req_stops) else $error("overflow left run or flag wrong");
   a_req_pulse: assert property (p_req_pulse) else $error("request longer than one cycle");
   a_req_cause: assert property (p_req_cause) else $error("request without a run");
   a_run_start: assert property (p_run_start) else $error("run rose without enabled set");
   a_run_end: assert property (p_run_end) else $error("run fell without cause");
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped uncleared");
   a_flag_set: assert property (p_flag_set) else $error("flag rose without overflow");
   a_rdata_frozen: assert property (p_rdata_frozen) else $error("read taken while running");
   c_ovf: cover property (conv_irq_req);
   c_stop: cover property ($fell(count_run_bit) && !conv_irq_req);
   c_flag_clear: cover property ($fell(conv_irq_flag));
endmodule
bind trcoc_top trcoc_properties u_trcoc_properties (.clk_sys(clk_sys), .rst(rst),
   .conv_enable_bit(conv_enable_bit), .run_set(run_set), .run_clear(run_clear),
   .irq_flag_clear(irq_flag_clear), .acc_rdata(acc_rdata), .count_run_bit(count_run_bit),
   .conv_irq_flag(conv_irq_flag), .conv_irq_req(conv_irq_req));

// ### bench/trcoc_rc_osc_model.sv
// behavioural rc oscillator on a touch pad
module trcoc_rc_osc_model (
   input  wire logic       run,
   input  wire logic [7:0] half_ns,
   output logic            osc
);
   timeunit 1ns;
   timeprecision 100ps;
   // a touch lengthens half_ns; odd offset keeps edges off the clock edges
   initial
   begin
      osc = 1'b0;
      #0.5;
      forever
      begin
         #(half_ns);
         osc = run ? ~osc : 1'b0;
      end
   end
endmodule

// ### rtl/trcoc_counter.sv
// one 16-bit counter with buffered low byte access
module trcoc_counter
   import trcoc_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       inc,
   input  wire logic       wr_low,
   input  wire logic       wr_high,
   input  wire logic       rd_high,
   input  wire logic [7:0] wdata,
   output logic [15:0]     count,
   output logic [7:0]      low_latch,
   output logic            wrap
);
   typedef struct packed {
      logic [15:0] cnt;
      logic [7:0]  wbuf;
      logic [7:0]  rlatch;
   } trcoc_cnt_state_t;

   trcoc_cnt_state_t st_r;
   trcoc_cnt_state_t st_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // wrap is combinational from the increment and the current count, so it lands in the same cycle
   assign wrap      = inc && (st_r.cnt == TRCOC_CNT_ALLONES);
   assign count     = st_r.cnt;
   assign low_latch = st_r.rlatch;

   // next state: software load has priority, increments never overlap it
   always_comb
   begin
      st_nxt = st_r;
      if (wr_low)
      begin
         st_nxt.wbuf = wdata;
      end
      if (wr_high)
      begin
         st_nxt.cnt = {wdata, st_r.wbuf};
      end
      else if (inc)
      begin
         st_nxt.cnt = st_r.cnt + 16'h0001;
      end
      if (rd_high)
      begin
         st_nxt.rlatch = st_r.cnt[7:0];
      end
   end

   // state register
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         st_r <= '{cnt: TRCOC_CNT_RST, wbuf: TRCOC_BYTE_RST, rlatch: TRCOC_BYTE_RST};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
endmodule

// ### rtl/trcoc_pkg.sv
// package for the touch rc-oscillator counter block
package trcoc_pkg;
   localparam int unsigned TRCOC_CNT_W       = 16;
   localparam int unsigned TRCOC_REF_DIV     = 4;
   localparam logic [7:0]  TRCOC_BYTE_RST    = 8'h00;
   localparam logic [15:0] TRCOC_CNT_RST     = 16'h0000;
   localparam logic [15:0] TRCOC_CNT_ALLONES = 16'hFFFF;
   localparam int unsigned TRCOC_ENABLE_BIT  = 1;   // position in conv_control_reg
   localparam int unsigned TRCOC_OVSEL_BIT   = 0;   // position in conv_control_reg
   localparam int unsigned TRCOC_RUN_BIT     = 4;   // position in conv_clock_control_reg
   localparam int unsigned TRCOC_IRQ_BIT     = 5;   // position in high interrupt reg
   localparam logic [1:0]  TRCOC_DIV_RST     = 2'h0;
   localparam logic        TRCOC_SRC_REF     = 1'b0;
   localparam logic        TRCOC_SRC_MEAS    = 1'b1;
   // byte register selectors for software access
   typedef enum logic [1:0] {
      TRCOC_SEL_REF_LOW,
      TRCOC_SEL_REF_HIGH,
      TRCOC_SEL_MEAS_LOW,
      TRCOC_SEL_MEAS_HIGH
   } trcoc_sel_t;
endpackage

// ### rtl/trcoc_top.sv
// touch measurement: reference and rc-oscillator counters with overflow stop
module trcoc_top
   import trcoc_pkg::*;
#(
   parameter int unsigned REF_DIV = TRCOC_REF_DIV
)
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       conv_enable_bit,
   input  wire logic       overflow_source_select,
   input  wire logic       ref_clock_select_bit0,
   input  wire logic       ref_clock_select_bit1,
   input  wire logic       ref_clock_select_bit2,
   input  wire logic       run_set,
   input  wire logic       run_clear,
   input  wire logic       irq_flag_clear,
   input  wire logic       rc_osc_in,
   input  wire logic       acc_wr,
   input  wire logic       acc_rd,
   input  wire trcoc_sel_t acc_sel,
   input  wire logic [7:0] acc_wdata,
   output logic [7:0]      acc_rdata,
   output logic            count_run_bit,
   output logic            conv_irq_flag,
   output logic            conv_irq_req
);
   // all control state in one record, registered once per clock
   typedef struct packed {
      logic       osc_s1;  // first synchroniser stage, read only by the second
      logic       osc_s2;
      logic       osc_s3;  // previous level for the edge detector
      logic [1:0] div;     // reference prescaler
      logic       run;
      logic       irq;     // sticky converter flag
      logic       irq_req; // one-cycle request pulse
      logic [7:0] rdata;
   } trcoc_state_t;

   // registered state and its next value
   trcoc_state_t st_r;
   trcoc_state_t st_nxt;

   // counter indices inside the generate loop
   localparam int unsigned NUM_CNT  = 2;
   localparam int unsigned REF_IDX  = 0;
   localparam int unsigned MEAS_IDX = 1;

   // per-counter views of the two counters
   logic [NUM_CNT-1:0][15:0] cnt_val;
   logic [NUM_CNT-1:0][7:0]  cnt_latch;
   logic [NUM_CNT-1:0]       cnt_wrap;
   logic [NUM_CNT-1:0]       cnt_inc;

   // named views used by the control logic
   logic [15:0] ref_count;
   logic [15:0] meas_count;
   logic [7:0]  ref_latch;
   logic [7:0]  meas_latch;
   logic        ref_wrap;
   logic        meas_wrap;
   logic        ref_tick;
   logic        osc_rise;
   logic        ref_inc;
   logic        meas_inc;
   logic        stop_evt;
   logic        sw_ok;
   logic        wr_ok;
   logic        rd_ok;
   logic [1:0]  sel_bits;
   logic        sel_chan;
   logic        sel_high;

   ////////////////////////////////////////////////////////////////////////////
   // elaboration checks: values the logic cannot serve
   // the two-bit prescaler wraps at four, so no other divider can be honoured
   if (REF_DIV != 4)
   begin : g_div_check
      $error("reference divider must be 4");
   end
   // the byte access splits each counter into exactly two bytes
   if (TRCOC_CNT_W != 16)
   begin : g_width_check
      $error("counter width must be 16");
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock source and counting enables
   // select bit0 picks the divided clock; bits 1 and 2 are kept for software but unused
   assign ref_tick  = ref_clock_select_bit0 ? (st_r.div == 2'(REF_DIV - 1)) : 1'b1;
   // edge detect reads only the second and third stages of the synchroniser
   assign osc_rise  = st_r.osc_s2 && !st_r.osc_s3;
   assign ref_inc   = st_r.run && conv_enable_bit && ref_tick;
   assign meas_inc  = st_r.run && conv_enable_bit && osc_rise;
   // only the selected counter's wrap ends the measurement
   assign stop_evt  = (overflow_source_select == TRCOC_SRC_MEAS) ? meas_wrap : ref_wrap;
   // software is shut out while counting so a reader never sees a moving count
   assign sw_ok     = !st_r.run;
   assign wr_ok     = acc_wr && sw_ok;
   assign rd_ok     = acc_rd && sw_ok;

   // split the selector: upper bit picks the counter, lower bit the byte half
   assign sel_bits  = acc_sel;
   assign sel_chan  = sel_bits[1];
   assign sel_high  = sel_bits[0];

   ////////////////////////////////////////////////////////////////////////////
   // the two counters: index 0 is the reference, index 1 the measurement
   // the channel is the upper select bit, the byte half the lower one
   for (genvar g = 0; g < NUM_CNT; g++)
   begin : g_cnt
      trcoc_counter u_cnt
      (
         .clk_sys   (clk_sys),
         .rst       (rst),
         .inc       (cnt_inc[g]),
         .wr_low    (wr_ok && (sel_chan == 1'(g)) && !sel_high),
         .wr_high   (wr_ok && (sel_chan == 1'(g)) && sel_high),
         .rd_high   (rd_ok && (sel_chan == 1'(g)) && sel_high),
         .wdata     (acc_wdata),
         .count     (cnt_val[g]),
         .low_latch (cnt_latch[g]),
         .wrap      (cnt_wrap[g])
      );
   end

   // named views of the counter array for the control logic
   assign cnt_inc    = {meas_inc, ref_inc};
   assign ref_count  = cnt_val[REF_IDX];
   assign meas_count = cnt_val[MEAS_IDX];
   assign ref_latch  = cnt_latch[REF_IDX];
   assign meas_latch = cnt_latch[MEAS_IDX];
   assign ref_wrap   = cnt_wrap[REF_IDX];
   assign meas_wrap  = cnt_wrap[MEAS_IDX];

   ////////////////////////////////////////////////////////////////////////////
   // control next state
   // later assignments win: software clear, then software set, then the overflow
   always_comb
   begin
      st_nxt         = st_r;
      // the pin passes two flops; the third stage only remembers the last level
      st_nxt.osc_s1  = rc_osc_in;
      st_nxt.osc_s2  = st_r.osc_s1;
      st_nxt.osc_s3  = st_r.osc_s2;
      st_nxt.irq_req = 1'b0;
      // prescaler free-runs only while counting so each run starts aligned
      st_nxt.div     = (st_r.run && conv_enable_bit) ? st_r.div + 2'h1 : TRCOC_DIV_RST;
      // a set in the same cycle as a clear wins over the clear
      if (run_clear)
      begin
         st_nxt.run = 1'b0;
      end
      if (run_set && conv_enable_bit)
      begin
         st_nxt.run = 1'b1;
      end
      // software clear of the sticky flag
      if (irq_flag_clear)
      begin
         st_nxt.irq = 1'b0;
      end
      // overflow wins over both the run set and the flag clear
      if (stop_evt)
      begin
         st_nxt.run     = 1'b0;
         st_nxt.irq     = 1'b1;
         st_nxt.irq_req = 1'b1;
      end
      // read data: high reads live byte, low reads the latched byte
      if (rd_ok)
      begin
         unique case (acc_sel)
            TRCOC_SEL_REF_LOW:   st_nxt.rdata = ref_latch;
            TRCOC_SEL_REF_HIGH:  st_nxt.rdata = ref_count[15:8];
            TRCOC_SEL_MEAS_LOW:  st_nxt.rdata = meas_latch;
            TRCOC_SEL_MEAS_HIGH: st_nxt.rdata = meas_count[15:8];
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         st_r <= '{
            osc_s1:  1'b0,
            osc_s2:  1'b0,
            osc_s3:  1'b0,
            div:     TRCOC_DIV_RST,
            run:     1'b0,
            irq:     1'b0,
            irq_req: 1'b0,
            rdata:   TRCOC_BYTE_RST
         };
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // outputs come straight from the state register, no logic after the flops
   assign acc_rdata     = st_r.rdata;
   assign count_run_bit = st_r.run;
   assign conv_irq_flag = st_r.irq;
   assign conv_irq_req  = st_r.irq_req;
endmodule
